/* src/wdog_map.vh */
// Register offsets, field positions, reset values and timing counts for the sleep-killable watchdog.
`ifndef WDOG_MAP_VH
`define WDOG_MAP_VH

// Register offsets on the CPU register port.
`define WD_ADDR_W              8
`define WD_OFS_CTRL_STATUS     8'h36
`define WD_OFS_IRQ_STATUS      8'h37
`define WD_OFS_IRQ_MASK        8'h38
`define WD_OFS_COUNT           8'h39

// Field positions of the control/status register.
`define WD_BIT_ON              7
`define WD_BIT_KILL            6
`define WD_BIT_FLAG            5
`define WD_BIT_SEL_HI          1
`define WD_BIT_SEL_LO          0

// Field positions of the interrupt status and mask registers.
`define WD_IRQ_W               3
`define WD_IRQ_EXPIRY          0
`define WD_IRQ_SLEEP_KILL      1
`define WD_IRQ_OFF_ATTEMPT     2

// Reset values.
`define WD_CTRL_RESET          8'h00
`define WD_SEL_RESET           2'h0
`define WD_IRQ_MASK_RESET      3'h0

// Tick timing: the counter steps at four hertz.
`define WD_TICK_PERIOD_NS      250000000
`define WD_CLK_PERIOD_NS       40
`define WD_TICK_CYCLES         (`WD_TICK_PERIOD_NS / `WD_CLK_PERIOD_NS)

// Ticks loaded for each period select code.
`define WD_CNT_W               5
`define WD_LOAD_SEL0           5'h02
`define WD_LOAD_SEL1           5'h04
`define WD_LOAD_SEL2           5'h08
`define WD_LOAD_SEL3           5'h10

`endif

/* src/sleep_killable_watchdog.v */
// Watchdog timer with write-once enable, sleep-kill feature, expiry flag and register port.
//
// The address-and-strobe port was chosen for this implementation.
`include "wdog_map.vh"

module sleep_killable_watchdog #(
    parameter TICK_CYCLES = `WD_TICK_CYCLES,
    parameter TICK_W      = 23
) (
    // Clock and reset.
    input  wire       sys_clk_in,
    input  wire       rst_n_in,
    // CPU register port.
    input  wire [7:0] reg_addr_in,
    input  wire [7:0] reg_wdata_in,
    input  wire       reg_wr_in,
    input  wire       reg_rd_in,
    output wire [7:0] reg_rdata_out,
    // Processor low-power state.
    input  wire       sleep_in,
    // Chip reset request and interrupt.
    output wire       wdog_reset_out,
    output wire       irq_out
);

    // Last prescaler count; the 32-bit difference is cut to the prescaler width on purpose.
    localparam [31:0]          TICK_LAST_FULL = TICK_CYCLES - 1;
    localparam [TICK_W-1:0]    TICK_LAST      = TICK_LAST_FULL[TICK_W-1:0];
    // One step of the prescaler and of the watchdog counter.
    localparam [TICK_W-1:0]    PRESC_ONE      = {{(TICK_W-1){1'b0}}, 1'b1};
    localparam [`WD_CNT_W-1:0] CNT_ONE        = {{(`WD_CNT_W-1){1'b0}}, 1'b1};

    // Kill sequence states, one-hot.
    localparam [3:0] KILL_FRESH   = 4'h1; // No control write since reset.
    localparam [3:0] KILL_ARMED   = 4'h2; // First write held a one in the kill bit.
    localparam [3:0] KILL_ENGAGED = 4'h4; // Second write held a zero: sleep now parks.
    localparam [3:0] KILL_CLOSED  = 4'h8; // Sequence over without engaging.

    // Decoded register accesses.
    wire sel_ctrl  = (reg_addr_in == `WD_OFS_CTRL_STATUS);
    wire sel_ista  = (reg_addr_in == `WD_OFS_IRQ_STATUS);
    wire sel_imask = (reg_addr_in == `WD_OFS_IRQ_MASK);
    wire sel_count = (reg_addr_in == `WD_OFS_COUNT);
    wire wr_ctrl   = reg_wr_in & sel_ctrl;
    wire rd_ctrl   = reg_rd_in & sel_ctrl;

    // State registers.
    reg [TICK_W-1:0]         presc_q;
    reg                      tick_q;
    reg [`WD_CNT_W-1:0]      count_q;
    reg                      on_q;
    reg [1:0]                sel_q;
    reg                      flag_q;
    reg [3:0]                kill_state_q;
    reg                      kill_read_q;
    reg                      parked_q;
    reg                      reset_q;
    reg [`WD_IRQ_W-1:0]      ista_q;
    reg [`WD_IRQ_W-1:0]      imask_q;
    reg [7:0]                rdata_q;

    // Next values.
    reg [`WD_CNT_W-1:0]      count_d;
    reg                      on_d;
    reg [1:0]                sel_d;
    reg                      flag_d;
    reg [3:0]                kill_state_d;
    reg                      kill_read_d;
    wire [`WD_IRQ_W-1:0]     ista_d;
    reg [`WD_IRQ_W-1:0]      imask_d;
    reg [7:0]                rdata_d;
    reg [`WD_IRQ_W-1:0]      events;

    // Count loaded for a period select code; each code doubles the tick count.
    // The tick phase is free, so the first tick may come at once: that gives the minimum period.
    function [`WD_CNT_W-1:0] load_for;
        input [1:0] code;
        begin
            case (code)
                2'h0:    load_for = `WD_LOAD_SEL0;
                2'h1:    load_for = `WD_LOAD_SEL1;
                2'h2:    load_for = `WD_LOAD_SEL2;
                default: load_for = `WD_LOAD_SEL3;
            endcase
        end
    endfunction

    // The kill feature is engaged only after the two-write order.
    wire kill_engaged = (kill_state_q == KILL_ENGAGED);
    // A service write restarts a running counter and so keeps it from expiring.
    wire service      = wr_ctrl & reg_wdata_in[`WD_BIT_FLAG] & on_q;
    // Sleep with the kill feature engaged parks an enabled watchdog.
    wire parked       = sleep_in & kill_engaged & on_q;
    // The counter runs while enabled and not parked; leaving sleep resumes it.
    wire running      = on_q & ~parked;
    // Expiry is a tick that finds the count at one, unless a service write lands in that cycle.
    // Without the service term a well-timed service could still lose the race to the tick.
    wire expire       = running & tick_q & (count_q == CNT_ONE) & ~service;
    // First cycle of a parked sleep.
    wire park_entry   = parked & ~parked_q;

    // Free-running prescaler producing the four hertz tick; its phase is unrelated to enabling.
    // Keeping it free avoids a second reset path but costs up to one tick of period spread.
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            presc_q <= {TICK_W{1'b0}};
            tick_q  <= 1'b0;
        end else if (presc_q == TICK_LAST) begin
            presc_q <= {TICK_W{1'b0}};
            tick_q  <= 1'b1;
        end else begin
            presc_q <= presc_q + PRESC_ONE;
            tick_q  <= 1'b0;
        end
    end

    // Kill sequence: only the first two control writes after a reset count.
    // A single stray write can arm the feature but never engage it.
    always @* begin
        kill_state_d = kill_state_q;
        kill_read_d  = kill_read_q;
        case (kill_state_q)
            KILL_FRESH: begin
                if (wr_ctrl) begin
                    // The first write fixes what the kill bit reads back.
                    kill_read_d = reg_wdata_in[`WD_BIT_KILL];
                    if (reg_wdata_in[`WD_BIT_KILL])
                        kill_state_d = KILL_ARMED;
                    else
                        kill_state_d = KILL_CLOSED;
                end
            end
            KILL_ARMED: begin
                if (wr_ctrl) begin
                    if (reg_wdata_in[`WD_BIT_KILL])
                        kill_state_d = KILL_CLOSED;
                    else
                        kill_state_d = KILL_ENGAGED;
                end
            end
            KILL_ENGAGED: begin
                kill_state_d = KILL_ENGAGED;
            end
            KILL_CLOSED: begin
                kill_state_d = KILL_CLOSED;
            end
            default: begin
                kill_state_d = KILL_FRESH;
            end
        endcase
        // Expiry resets the chip, so the sequence starts over.
        if (expire) begin
            kill_state_d = KILL_FRESH;
            kill_read_d  = 1'b0;
        end
    end

    // Control, counter and flag next-state logic.
    // A write loads the period code, may enable, may service, and may clear the flag.
    always @* begin
        count_d = count_q;
        on_d    = on_q;
        sel_d   = sel_q;
        flag_d  = flag_q;
        events  = {`WD_IRQ_W{1'b0}};

        // Register writes to the control/status register.
        if (wr_ctrl) begin
            sel_d = reg_wdata_in[`WD_BIT_SEL_HI:`WD_BIT_SEL_LO];
            if (reg_wdata_in[`WD_BIT_ON] && !on_q) begin
                on_d    = 1'b1;
                count_d = load_for(reg_wdata_in[`WD_BIT_SEL_HI:`WD_BIT_SEL_LO]);
            end else if (!reg_wdata_in[`WD_BIT_ON] && on_q) begin
                // The enable is write-once; the attempt is only reported.
                events[`WD_IRQ_OFF_ATTEMPT] = 1'b1;
            end
            if (!reg_wdata_in[`WD_BIT_FLAG])
                flag_d = 1'b0;
        end

        // Reading the control/status register clears the flag; the old value is returned.
        if (rd_ctrl)
            flag_d = 1'b0;

        // Counter: service reload, parked hold at full load, or one step per tick.
        if (service) begin
            count_d = load_for(sel_d);
        end else if (parked) begin
            count_d = load_for(sel_q);
        end else if (running && tick_q) begin
            count_d = count_q - CNT_ONE;
        end

        // Entering a parked sleep is reported once per entry.
        if (park_entry)
            events[`WD_IRQ_SLEEP_KILL] = 1'b1;

        // Expiry resets the controls and leaves the flag set; the set beats any clear.
        if (expire) begin
            on_d    = 1'b0;
            sel_d   = `WD_SEL_RESET;
            count_d = {`WD_CNT_W{1'b0}};
            flag_d  = 1'b1;
            events[`WD_IRQ_EXPIRY] = 1'b1;
        end
    end

    // Interrupt status bits, write-one-to-clear; a new event wins over a clear in the same cycle.
    genvar gi;
    generate
        for (gi = 0; gi < `WD_IRQ_W; gi = gi + 1) begin : g_ista
            assign ista_d[gi] = events[gi] | (ista_q[gi] & ~(reg_wr_in & sel_ista & reg_wdata_in[gi]));
        end
    endgenerate

    // Interrupt mask, replaced by a write to its offset.
    always @* begin
        imask_d = imask_q;
        if (reg_wr_in && sel_imask)
            imask_d = reg_wdata_in[`WD_IRQ_W-1:0];
    end

    // Read data, valid in the cycle after the read strobe; unmapped offsets read zero.
    always @* begin
        rdata_d = 8'h00;
        if (reg_rd_in) begin
            if (sel_ctrl) begin
                rdata_d[`WD_BIT_ON]                    = on_q;
                rdata_d[`WD_BIT_KILL]                  = kill_read_q;
                rdata_d[`WD_BIT_FLAG]                  = flag_q;
                rdata_d[`WD_BIT_SEL_HI:`WD_BIT_SEL_LO] = sel_q;
            end else if (sel_ista) begin
                rdata_d[`WD_IRQ_W-1:0] = ista_q;
            end else if (sel_imask) begin
                rdata_d[`WD_IRQ_W-1:0] = imask_q;
            end else if (sel_count) begin
                rdata_d[`WD_CNT_W-1:0] = count_q;
            end
        end
    end

    // Control and counter flip-flops; the external reset clears the flag as well.
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            count_q <= {`WD_CNT_W{1'b0}};
            on_q    <= 1'b0;
            sel_q   <= `WD_SEL_RESET;
            flag_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            on_q    <= on_d;
            sel_q   <= sel_d;
            flag_q  <= flag_d;
        end
    end

    // Kill sequence flip-flops.
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            kill_state_q <= KILL_FRESH;
            kill_read_q  <= 1'b0;
        end else begin
            kill_state_q <= kill_state_d;
            kill_read_q  <= kill_read_d;
        end
    end

    // Parked-sleep history, so that each entry is reported once.
    always @(posedge sys_clk_in) begin
        if (!rst_n_in)
            parked_q <= 1'b0;
        else
            parked_q <= parked;
    end

    // Reset request: a one-cycle pulse in the cycle after expiry.
    always @(posedge sys_clk_in) begin
        if (!rst_n_in)
            reset_q <= 1'b0;
        else
            reset_q <= expire;
    end

    // Interrupt status and mask flip-flops.
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            ista_q  <= {`WD_IRQ_W{1'b0}};
            imask_q <= `WD_IRQ_MASK_RESET;
        end else begin
            ista_q  <= ista_d;
            imask_q <= imask_d;
        end
    end

    // Read data flip-flop; a value stands for one cycle and then returns to zero.
    always @(posedge sys_clk_in) begin
        if (!rst_n_in)
            rdata_q <= 8'h00;
        else
            rdata_q <= rdata_d;
    end

    // Outputs.
    assign reg_rdata_out  = rdata_q;
    assign wdog_reset_out = reset_q;
    assign irq_out        = |(ista_q & imask_q);

endmodule // sleep_killable_watchdog

/* bench/sleep_killable_watchdog_assertions.sv */
// Port-level assertions for the sleep-killable watchdog.
module wdog_checker (
    // Clock and reset.
    input wire       sys_clk_in,
    input wire       rst_n_in,
    // Register port and outputs.
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire       reg_wr_in,
    input wire       reg_rd_in,
    input wire [7:0] reg_rdata_out,
    input wire       wdog_reset_out,
    input wire       irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Decoded control/status read.
    wire rd_ctrl = reg_rd_in && (reg_addr_in == 8'h36);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Read data stand only in the cycle after a read.
    property p_rdata_idle; !$past(reg_rd_in) |-> reg_rdata_out == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
    property p_count_range; $past(reg_rd_in) && $past(reg_addr_in) == 8'h39 |-> reg_rdata_out <= 8'h10; endproperty
    a_count_range: assert property (p_count_range) else $error("counter above largest load");
    property p_unmapped;
        $past(reg_rd_in) && ($past(reg_addr_in) < 8'h36 || $past(reg_addr_in) > 8'h39) |-> reg_rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ctrl_layout; $past(rd_ctrl) |-> reg_rdata_out[4:2] == 3'h0; endproperty
    a_ctrl_layout: assert property (p_ctrl_layout) else $error("unused control bits set");
    // Expiry gives one pulse and leaves the watchdog off.
    property p_pulse; wdog_reset_out |=> !wdog_reset_out [*8]; endproperty
    a_pulse: assert property (p_pulse) else $error("expiry pulse repeated");
    property p_post_expiry; $past(wdog_reset_out, 2) && $past(rd_ctrl) |-> reg_rdata_out == 8'h20; endproperty
    a_post_expiry: assert property (p_post_expiry) else $error("state after expiry wrong");
    property p_irq_mask;
        reg_wr_in && reg_addr_in == 8'h38 && reg_wdata_in[2:0] == 3'h0 |=> !irq_out;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt still high");
    // A load or service write keeps expiry off for seven cycles, starting two cycles after the write.
    property p_no_early;
        reg_wr_in && reg_addr_in == 8'h36 && reg_wdata_in[7] && reg_wdata_in[5] |-> ##2 !wdog_reset_out [*7];
    endproperty
    a_no_early: assert property (p_no_early) else $error("expiry too soon after load");
endmodule // wdog_checker

/* bench/tb_sleep_killable_watchdog.sv */
// Self-checking testbench for the sleep-killable watchdog.
module tb_sleep_killable_watchdog;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int T = 10;
    logic       sys_clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, sleep_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
    wire  [7:0] reg_rdata_out;
    wire        wdog_reset_out, irq_out;
    int         err_count = 0, check_count = 0, n;
    sleep_killable_watchdog #(.TICK_CYCLES(T), .TICK_W(4)) sleep_killable_watchdog_i (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .sleep_in(sleep_in),
        .wdog_reset_out(wdog_reset_out), .irq_out(irq_out));
    // Clock at 25 MHz.
    initial begin
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    // Counts one comparison and reports a mismatch.
    task chk(input bit ok, input string m);
        check_count++;
        if (!ok) begin
            err_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in) {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
        @(posedge sys_clk_in) reg_wr_in <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_in) {reg_addr_in, reg_rd_in} <= {a, 1'b1};
        @(posedge sys_clk_in) reg_rd_in <= 1'b0;
        @(negedge sys_clk_in);
        chk(reg_rdata_out === e, "read data mismatch");
    endtask
    // Counts cycles until the reset pulse, 400 at most.
    task wait_pulse();
        n = 0;
        do begin
            @(negedge sys_clk_in);
            n++;
        end while (wdog_reset_out !== 1'b1 && n < 400);
    endtask
    task t_reset();
        rd(8'h36, 8'h00);
        rd(8'h39, 8'h00);
        rd(8'h38, 8'h00);
        rd(8'h40, 8'h00);
        $display("t_reset done");
    endtask
    task t_kill();
        wr(8'h36, 8'hc0);
        rd(8'h36, 8'hc0);
        wr(8'h36, 8'h00);
        rd(8'h36, 8'hc0);
        @(posedge sys_clk_in) sleep_in <= 1'b1;
        wait_pulse();
        chk(n == 400, "expiry while parked");
        rd(8'h39, 8'h02);
        rd(8'h37, 8'h06);
        @(posedge sys_clk_in) sleep_in <= 1'b0;
        wait_pulse();
        chk(n <= 2 * T + 2, "no resume after sleep");
        rd(8'h36, 8'h20);
        $display("t_kill done");
    endtask
    task t_periods();
        for (int s = 0; s < 4; s++) begin
            wr(8'h36, 8'ha0 | 8'(s));
            wait_pulse();
            chk(n >= ((2 << s) - 1) * T + 2 && n <= (2 << s) * T + 1, "period length");
            rd(8'h36, 8'h20);
            rd(8'h36, 8'h00);
        end
        $display("t_periods done");
    endtask
    task t_service();
        wr(8'h36, 8'ha0);
        rd(8'h36, 8'h80);
        wr(8'h37, 8'h07);
        repeat (12) begin
            repeat (T - 3) @(posedge sys_clk_in);
            wr(8'h36, 8'ha0);
        end
        rd(8'h37, 8'h00);
        rd(8'h36, 8'h80);
        wr(8'h38, 8'h01);
        wait_pulse();
        chk(n <= 2 * T + 1, "no expiry without service");
        chk(irq_out === 1'b1, "interrupt missing");
        wr(8'h38, 8'h00);
        @(negedge sys_clk_in);
        chk(irq_out === 1'b0, "interrupt not masked");
        wr(8'h38, 8'h01);
        wr(8'h37, 8'h01);
        @(negedge sys_clk_in);
        chk(irq_out === 1'b0, "interrupt not cleared");
        wr(8'h36, 8'h00);
        rd(8'h36, 8'h00);
        $display("t_service done");
    endtask
    task conclude();
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (8) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        t_reset();
        t_kill();
        t_periods();
        t_service();
        conclude();
    end
    // Watchdog against a hang.
    initial begin
        #240000;
        err_count++;
        conclude();
    end
endmodule // tb_sleep_killable_watchdog
bind sleep_killable_watchdog wdog_checker wdog_checker_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .wdog_reset_out(wdog_reset_out), .irq_out(irq_out));
